/* File: logic/supervisor_pkg.sv */
// Constants for the supply supervisor with watchdog and chip-enable gating
package supervisor_pkg;

  // ****************************************
  // Time base and documented times
  // ****************************************
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_KHZ = CLK_MHZ * 1000;
  localparam int unsigned RESET_HOLD_MS = 200;
  localparam int unsigned WD_PERIOD_MS = 1600;
  localparam int unsigned WD_SERVICE_MS = 1400;
  localparam int unsigned CE_LINGER_US = 15;
  localparam int unsigned KICK_MIN_NS = 50;

  // Cycle counts; longest times round down, least times round up
  localparam logic [31:0] RESET_HOLD_CYC = 32'(RESET_HOLD_MS * CLK_KHZ);
  localparam logic [31:0] WD_PERIOD_CYC = 32'(WD_PERIOD_MS * CLK_KHZ);
  localparam logic [31:0] WD_SERVICE_CYC = 32'(WD_SERVICE_MS * CLK_KHZ);
  localparam logic [11:0] CE_LINGER_CYC = 12'(CE_LINGER_US * CLK_MHZ);
  localparam logic [3:0] KICK_PULSE_CYC = 4'((KICK_MIN_NS * CLK_MHZ + 999) / 1000);

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
  localparam int CTRL_SW_RESET_BIT = 0;
  localparam int ST_RESET_BIT = 0;
  localparam int ST_HOLD_BIT = 1;
  localparam int ST_BACKUP_BIT = 2;
  localparam int ST_ARMED_BIT = 3;
  localparam int ST_SEALED_BIT = 4;
  localparam int ST_GATE_BIT = 5;
  localparam int ST_PFLAG_BIT = 6;
  localparam int ST_WD_TRIP_BIT = 7;

  // ****************************************
  // Synchroniser lanes
  // ****************************************
  localparam int SYNC_W = 8;
  localparam int SY_SUPPLY = 0;
  localparam int SY_ABOVE_CELL = 1;
  localparam int SY_PF_SENSE = 2;
  localparam int SY_MR = 3;
  localparam int SY_KICK = 4;
  localparam int SY_CE_IN = 5;
  localparam int SY_CE_PIN = 6;
  localparam int SY_PF_PIN = 7;
  localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 8'he8;

  typedef enum logic [2:0] {
    GATE_PASS = 3'b001,
    GATE_LINGER = 3'b010,
    GATE_BLOCK = 3'b100
  } gate_e;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CTRL = 2'b01,
    SEL_STATUS = 2'b10
  } reg_sel_e;

endpackage : supervisor_pkg

/* File: logic/level_sync.sv */
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  // First stage feeds only the second stage
  logic [W-1:0] stage1_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stage1_r <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      stage1_r <= i_async;
      o_sync <= stage1_r;
    end
  end

endmodule : level_sync

/* File: logic/supply_supervisor_watchdog.sv */
// Supply supervisor: reset generator, watchdog, chip-enable gate, seal
//
// Behaviour
// R1: Reset held low while supply is below trip; released after hold time.
// R2: Every reset assertion lasts at least the full reset hold time.
// R3: Hold timer clears while supply is low, restarts when it returns.
// R4: Manual reset low asserts reset; held low plus hold time after release.
// R5: Manual reset ignored during hold time while freshness seal is armed.
// R6: Seal arms when flag pin held low through hold; seals at supply drop.
// R7: Sealed: cell stays disconnected until supply next rises above trip.
// R8: Seal arms only with manual reset high; afterwards manual reset irrelevant.
// R9: Watchdog not kicked within its period asserts reset.
// R10: Watchdog timer clears on reset or any kick edge, 50 ns pulses seen.
// R11: Watchdog stays cleared during reset, counts right after release.
// R12: Floating kick pin: internal driver pulses high at 7/8 period.
// R13: Reset released: chip-enable output follows chip-enable input.
// R14: Input low at reset: gate lingers up to 15 us or until input high.
// R15: Input high at power-down: gate disables at once, input floats.
// R16: Gate stays disabled for the whole reset hold time.
// R17: Disabled gate pulls chip-enable output high; pull-up off when enabled.
// R18: Power-fail flag low when sense below level, else high.
// R19: Supply below cell: comparison off, power-fail flag low.
// R20: During hold time power-fail flag forced high.
// R21: Backup mode only when supply below trip and below cell.
// R22: RAM fed from supply above trip, else from the higher source.
// R23: Backup mode: watchdog off, reset low, output high, input floating.
// R24: Hold and watchdog times are counters with parameter lengths.
// R25: Comparator and pin inputs synchronised before any decision uses them.
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
module supply_supervisor_watchdog #(
  parameter logic [31:0] HOLD_CYC = supervisor_pkg::RESET_HOLD_CYC,
  parameter logic [31:0] WD_CYC = supervisor_pkg::WD_PERIOD_CYC,
  parameter logic [31:0] SERVICE_CYC = supervisor_pkg::WD_SERVICE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_supply_ok,
  input wire logic i_supply_above_cell,
  input wire logic i_powerfail_sense_ok,
  input wire logic i_manual_reset_n,
  input wire logic i_watchdog_kick_in,
  output logic o_watchdog_kick_out,
  output logic o_watchdog_kick_oe,
  input wire logic i_chip_enable_in_n,
  output logic o_chip_enable_in_hiz,
  input wire logic i_chip_enable_out_n,
  output logic o_chip_enable_out_n,
  output logic o_chip_enable_out_oe,
  output logic o_chip_enable_pullup,
  input wire logic i_powerfail_flag_n,
  output logic o_powerfail_flag_n,
  output logic o_powerfail_flag_oe,
  output logic o_reset_n,
  output logic o_backup_mode,
  output logic o_ram_from_cell
);
  import supervisor_pkg::*;

  // ****************************************
  // Input synchronisation
  // ****************************************
  logic [SYNC_W-1:0] sy;
  logic sup_ok, above_cell, pf_ok, mr_n, kick, ce_in_n, ce_pin_n, pf_pin_n;

  level_sync #(
    .W(SYNC_W),
    .RST_VAL(SYNC_RST_VAL)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async({i_powerfail_flag_n, i_chip_enable_out_n, i_chip_enable_in_n,
              i_watchdog_kick_in, i_manual_reset_n, i_powerfail_sense_ok,
              i_supply_above_cell, i_supply_ok}),
    .o_sync(sy)
  ); // R25

  assign sup_ok = sy[SY_SUPPLY];
  assign above_cell = sy[SY_ABOVE_CELL];
  assign pf_ok = sy[SY_PF_SENSE];
  assign mr_n = sy[SY_MR];
  assign kick = sy[SY_KICK];
  assign ce_in_n = sy[SY_CE_IN];
  assign ce_pin_n = sy[SY_CE_PIN];
  assign pf_pin_n = sy[SY_PF_PIN];

  // ****************************************
  // Register bus decode
  // ****************************************
  function automatic reg_sel_e reg_sel(input logic [11:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr == CTRL_ADDR) begin
      sel = SEL_CTRL;
    end else if (addr == STATUS_ADDR) begin
      sel = SEL_STATUS;
    end
    return sel;
  endfunction : reg_sel

  logic apb_acc, apb_fire;
  logic [31:0] ctrl_r;
  logic wd_flag_r;
  logic sw_reset;
  reg_sel_e sel;

  assign apb_acc = i_psel && i_penable;
  assign apb_fire = apb_acc && o_pready;
  assign sel = reg_sel(i_paddr);
  assign sw_reset = ctrl_r[CTRL_SW_RESET_BIT];

  // ****************************************
  // Reset generator and hold timer
  // ****************************************
  logic rst_n_r, hold_run_r, armed_r, ready_r, sealed_r;
  logic [31:0] hold_cnt_r;
  logic backup, mr_low_eff, level_cause, wd_trip, hold_done;

  assign backup = !sup_ok && !above_cell; // R21
  // A seal armed during the hold must not be undone by a manual reset
  assign mr_low_eff = !mr_n && !(hold_run_r && armed_r); // R4 R5
  assign level_cause = !sup_ok || mr_low_eff || sw_reset; // R1 R23
  assign hold_done = !rst_n_r && hold_cnt_r == HOLD_CYC - 32'h1;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_n_r <= 1'b0;
      hold_run_r <= 1'b0;
      hold_cnt_r <= 32'h0;
    end else if (level_cause) begin
      rst_n_r <= 1'b0; // R1 R4
      hold_run_r <= 1'b0;
      hold_cnt_r <= 32'h0; // R3
    end else if (wd_trip) begin
      rst_n_r <= 1'b0; // R9
      hold_run_r <= 1'b1;
      hold_cnt_r <= 32'h0;
    end else if (hold_done) begin
      rst_n_r <= 1'b1; // R2
      hold_run_r <= 1'b0;
      hold_cnt_r <= 32'h0;
    end else if (!rst_n_r) begin
      hold_run_r <= 1'b1;
      hold_cnt_r <= hold_cnt_r + 32'h1; // R2 R24
    end
  end

  // ****************************************
  // Freshness seal
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      armed_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (!sup_ok) begin
      armed_r <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      // Pin readback trusted once own forced-high flag drive has settled
      if (hold_run_r && hold_cnt_r > 32'h3 && above_cell && mr_n &&
          (!pf_pin_n || !ce_pin_n)) begin
        armed_r <= 1'b1; // R6 R8
      end
      if (hold_done && !level_cause && armed_r) begin
        ready_r <= 1'b1; // R6
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sealed_r <= 1'b0;
    end else if (sup_ok) begin
      sealed_r <= 1'b0; // R7
    end else if (ready_r) begin
      sealed_r <= 1'b1; // R6
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  logic kick_d_r, kick_edge;
  logic [31:0] wd_cnt_r;
  logic [3:0] pulse_cnt_r;
  logic kick_out_r, kick_oe_r;

  assign kick_edge = kick ^ kick_d_r; // R10
  assign wd_trip = rst_n_r && !kick_edge && wd_cnt_r == WD_CYC - 32'h1; // R9

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      kick_d_r <= 1'b0;
      wd_cnt_r <= 32'h0;
    end else begin
      kick_d_r <= kick;
      if (!rst_n_r || kick_edge || wd_trip) begin
        wd_cnt_r <= 32'h0; // R10 R11 R23
      end else begin
        wd_cnt_r <= wd_cnt_r + 32'h1; // R11 R24
      end
    end
  end

  // Weak internal driver; an open pin echoes it back and so services itself
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pulse_cnt_r <= 4'h0;
      kick_out_r <= 1'b0;
      kick_oe_r <= 1'b0;
    end else begin
      if (rst_n_r && wd_cnt_r == SERVICE_CYC - 32'h1) begin
        pulse_cnt_r <= KICK_PULSE_CYC; // R12
      end else if (pulse_cnt_r != 4'h0) begin
        pulse_cnt_r <= pulse_cnt_r - 4'h1;
      end
      kick_out_r <= pulse_cnt_r != 4'h0; // R12
      kick_oe_r <= !backup; // R23
    end
  end

  // ****************************************
  // Chip-enable gate
  // ****************************************
  gate_e gate_st_r;
  logic [11:0] linger_cnt_r;
  logic ce_out_r, pullup_r, ce_oe_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      gate_st_r <= GATE_BLOCK;
      linger_cnt_r <= 12'h0;
    end else begin
      unique case (gate_st_r)
        GATE_PASS: begin
          linger_cnt_r <= 12'h0;
          if (!rst_n_r) begin
            // Let a write already under way finish
            gate_st_r <= (!ce_in_n && !backup) ? GATE_LINGER : GATE_BLOCK; // R14 R15
          end
        end
        GATE_LINGER: begin
          if (ce_in_n || backup || linger_cnt_r == CE_LINGER_CYC - 12'h1) begin
            gate_st_r <= GATE_BLOCK; // R14
          end else begin
            linger_cnt_r <= linger_cnt_r + 12'h1;
          end
        end
        GATE_BLOCK: begin
          if (rst_n_r && !backup) begin
            gate_st_r <= GATE_PASS; // R13 R16
          end
        end
      endcase
    end
  end

  // Registered path adds sync latency; no 3 ns pass-through here
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ce_out_r <= 1'b1;
      pullup_r <= 1'b1;
      ce_oe_r <= 1'b0;
    end else begin
      ce_out_r <= (gate_st_r == GATE_BLOCK) ? 1'b1 : ce_in_n; // R13 R17
      pullup_r <= gate_st_r == GATE_BLOCK; // R16 R17
      ce_oe_r <= 1'b1;
    end
  end

  // ****************************************
  // Power-fail flag and supply selection
  // ****************************************
  logic pf_r, pf_oe_r, backup_r, ram_cell_r;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pf_r <= 1'b0;
      pf_oe_r <= 1'b0;
      backup_r <= 1'b0;
      ram_cell_r <= 1'b0;
    end else begin
      if (!above_cell) begin
        pf_r <= 1'b0; // R19
      end else if (hold_run_r) begin
        pf_r <= 1'b1; // R20
      end else begin
        pf_r <= pf_ok; // R18
      end
      pf_oe_r <= 1'b1;
      backup_r <= backup; // R21
      ram_cell_r <= backup && !sealed_r; // R22 R7
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r, status;

  always_comb begin
    status = 32'h0;
    status[ST_RESET_BIT] = !rst_n_r;
    status[ST_HOLD_BIT] = hold_run_r;
    status[ST_BACKUP_BIT] = backup_r;
    status[ST_ARMED_BIT] = armed_r;
    status[ST_SEALED_BIT] = sealed_r;
    status[ST_GATE_BIT] = gate_st_r != GATE_BLOCK;
    status[ST_PFLAG_BIT] = pf_r;
    status[ST_WD_TRIP_BIT] = wd_flag_r;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= apb_acc && !pready_r;
      pslverr_r <= apb_acc && !pready_r && sel == SEL_NONE;
      if (apb_acc && !pready_r && !i_pwrite) begin
        prdata_r <= (sel == SEL_CTRL) ? ctrl_r : (sel == SEL_STATUS) ? status : 32'h0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_r <= CTRL_RESET_VAL;
    end else if (apb_fire && i_pwrite && sel == SEL_CTRL) begin
      ctrl_r <= i_pwdata;
    end
  end

  // Trip wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wd_flag_r <= 1'b0;
    end else if (wd_trip) begin
      wd_flag_r <= 1'b1;
    end else if (apb_fire && i_pwrite && sel == SEL_STATUS && i_pwdata[ST_WD_TRIP_BIT]) begin
      wd_flag_r <= 1'b0;
    end
  end

  assign o_prdata = prdata_r;
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_reset_n = rst_n_r;
  assign o_watchdog_kick_out = kick_out_r;
  assign o_watchdog_kick_oe = kick_oe_r;
  assign o_chip_enable_out_n = ce_out_r;
  assign o_chip_enable_out_oe = ce_oe_r;
  assign o_chip_enable_pullup = pullup_r;
  assign o_chip_enable_in_hiz = pullup_r;
  assign o_powerfail_flag_n = pf_r;
  assign o_powerfail_flag_oe = pf_oe_r;
  assign o_backup_mode = backup_r;
  assign o_ram_from_cell = ram_cell_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  property p_supply_low;
    !sup_ok |=> !o_reset_n ##1 !o_reset_n || sup_ok;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("reset not low on low supply"); // R1
  property p_hold_full;
    $rose(o_reset_n) |-> $past(hold_cnt_r) == HOLD_CYC - 32'h1;
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("reset released early"); // R2
  property p_timer_clear;
    !sup_ok |=> hold_cnt_r == 32'h0 && !hold_run_r;
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("hold timer not cleared"); // R3

  property p_manual;
    mr_low_eff |=> !o_reset_n && hold_cnt_r == 32'h0;
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset not honoured"); // R4

  property p_mr_ignored;
    hold_run_r && armed_r && sup_ok && !sw_reset && !hold_done && !wd_trip
      |=> hold_cnt_r == $past(hold_cnt_r) + 32'h1;
  endproperty
  a_mr_ignored: assert property (p_mr_ignored) else $error("hold disturbed while armed"); // R5

  property p_seal_keep;
    sealed_r |=> !o_ram_from_cell;
  endproperty
  a_seal_keep: assert property (p_seal_keep) else $error("cell used while sealed"); // R7

  property p_wd_trip;
    o_reset_n && wd_cnt_r == WD_CYC - 32'h1 && !kick_edge |=> !o_reset_n ##1 wd_cnt_r == 32'h0;
  endproperty
  a_wd_trip: assert property (p_wd_trip) else $error("watchdog expiry missed"); // R9

  property p_wd_kick;
    o_reset_n && kick_edge |=> wd_cnt_r == 32'h0;
  endproperty
  a_wd_kick: assert property (p_wd_kick) else $error("kick did not clear watchdog"); // R10

  property p_wd_held;
    !o_reset_n |=> wd_cnt_r == 32'h0;
  endproperty
  a_wd_held: assert property (p_wd_held) else $error("watchdog counts in reset"); // R11

  property p_gate_pass;
    gate_st_r == GATE_PASS |=> o_chip_enable_out_n == $past(ce_in_n) && !o_chip_enable_pullup;
  endproperty
  a_gate_pass: assert property (p_gate_pass) else $error("gate not passing"); // R13

  property p_linger;
    gate_st_r == GATE_LINGER && linger_cnt_r == CE_LINGER_CYC - 12'h1 |=> gate_st_r == GATE_BLOCK;
  endproperty
  a_linger: assert property (p_linger) else $error("linger too long"); // R14

  property p_linger_end;
    gate_st_r == GATE_LINGER && ce_in_n |=> gate_st_r == GATE_BLOCK ##1 o_chip_enable_pullup;
  endproperty
  a_linger_end: assert property (p_linger_end) else $error("linger not ended"); // R14

  property p_block_hold;
    gate_st_r == GATE_BLOCK && !o_reset_n |=> gate_st_r == GATE_BLOCK ##1 o_chip_enable_out_n;
  endproperty
  a_block_hold: assert property (p_block_hold) else $error("gate opened in reset"); // R16 R17

  property p_pf_cell;
    !above_cell |=> !o_powerfail_flag_n;
  endproperty
  a_pf_cell: assert property (p_pf_cell) else $error("flag not low below cell"); // R19
  property p_pf_hold;
    hold_run_r && above_cell |=> o_powerfail_flag_n;
  endproperty
  a_pf_hold: assert property (p_pf_hold) else $error("flag not forced high"); // R20
  c_wd_trip: cover property (wd_trip);
  c_linger: cover property (gate_st_r == GATE_LINGER ##1 gate_st_r == GATE_BLOCK);
  c_sealed: cover property ($rose(sealed_r));
  c_manual: cover property (!mr_n && o_reset_n ##1 !o_reset_n);

endmodule : supply_supervisor_watchdog

/* File: bench/cpu_ram_model.sv */
// Processor and RAM side of the supervisor pins, with pin resolution
`timescale 1ns/1ps
module cpu_ram_model (
  input wire logic i_sys_clk,
  input wire logic i_kick_drive_en,
  input wire logic i_kick_drive_lvl,
  input wire logic i_kick_out,
  input wire logic i_kick_oe,
  output logic o_kick_pin,
  input wire logic i_ground_ce,
  input wire logic i_ce_out_n,
  input wire logic i_ce_out_oe,
  output logic o_ce_pin,
  input wire logic i_ground_flag,
  input wire logic i_flag_n,
  input wire logic i_flag_oe,
  output logic o_flag_pin
);
  // ****************************************
  // Pin resolution
  // ****************************************
  // Released pins toggle, so a stale level never passes for a driven one
  logic tog_r = 1'b0;
  always_ff @(posedge i_sys_clk) begin
    tog_r <= ~tog_r;
  end
  // Processor driver overpowers the weak internal kick driver
  assign o_kick_pin = i_kick_drive_en ? i_kick_drive_lvl : (i_kick_oe ? i_kick_out : tog_r);
  assign o_ce_pin = i_ground_ce ? 1'b0 : (i_ce_out_oe ? i_ce_out_n : tog_r);
  assign o_flag_pin = i_ground_flag ? 1'b0 : (i_flag_oe ? i_flag_n : tog_r);
endmodule : cpu_ram_model

/* File: bench/tb_supply_supervisor_watchdog.sv */
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
module tb_supply_supervisor_watchdog;
  import supervisor_pkg::*;
  localparam int HOLD = 200;
  localparam int WD = 1600;
  localparam int SRV = 1400;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic supply_ok, above_cell, sense_ok, mr_n, kick_pin, kick_out, kick_oe, kick_en, kick_lvl;
  logic ce_in_n, ce_in_hiz, ce_pin, ce_out_n, ce_out_oe, ce_pullup, ground_ce;
  logic flag_pin, flag_n, flag_oe, ground_flag, reset_n, backup, ram_cell;
  logic [31:0] rd;
  logic err;
  int n;
  int err_count = 0;
  int n_tests = 0;

  supply_supervisor_watchdog #(.HOLD_CYC(32'(HOLD)), .WD_CYC(32'(WD)), .SERVICE_CYC(32'(SRV)))
  supply_supervisor_watchdog_i (.i_sys_clk(sys_clk), .i_rstn(rstn), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_supply_ok(supply_ok),
    .i_supply_above_cell(above_cell), .i_powerfail_sense_ok(sense_ok),
    .i_manual_reset_n(mr_n), .i_watchdog_kick_in(kick_pin), .o_watchdog_kick_out(kick_out),
    .o_watchdog_kick_oe(kick_oe), .i_chip_enable_in_n(ce_in_n),
    .o_chip_enable_in_hiz(ce_in_hiz), .i_chip_enable_out_n(ce_pin),
    .o_chip_enable_out_n(ce_out_n), .o_chip_enable_out_oe(ce_out_oe),
    .o_chip_enable_pullup(ce_pullup), .i_powerfail_flag_n(flag_pin),
    .o_powerfail_flag_n(flag_n), .o_powerfail_flag_oe(flag_oe), .o_reset_n(reset_n),
    .o_backup_mode(backup), .o_ram_from_cell(ram_cell));

  cpu_ram_model cpu_ram_model_i (.i_sys_clk(sys_clk), .i_kick_drive_en(kick_en),
    .i_kick_drive_lvl(kick_lvl), .i_kick_out(kick_out), .i_kick_oe(kick_oe),
    .o_kick_pin(kick_pin), .i_ground_ce(ground_ce), .i_ce_out_n(ce_out_n),
    .i_ce_out_oe(ce_out_oe), .o_ce_pin(ce_pin), .i_ground_flag(ground_flag),
    .i_flag_n(flag_n), .i_flag_oe(flag_oe), .o_flag_pin(flag_pin));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  task automatic chkw(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chkw

  // Cycle counts carry some slack for the two-flop input synchronisers
  task automatic in_range(input string what, input int lo, input int hi, input int cnt);
    n_tests++;
    if (cnt < lo || cnt > hi) begin
      err_count++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, cnt);
    end
  endtask : in_range

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc

  task automatic wait_rst(input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (reset_n !== lvl && cnt < lim) begin
      @(posedge sys_clk);
      cnt++;
    end
  endtask : wait_rst

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1);
    in_range("apb wait", 2, 2, k);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_powerup();
    supply_ok <= 1'b1;
    cyc(HOLD / 2);
    chk("flag in hold", 1'b1, flag_n);
    chk("pullup in hold", 1'b1, ce_pullup);
    chk("ce in hiz", 1'b1, ce_in_hiz);
    chk("ce out oe", 1'b1, ce_out_oe);
    chk("flag oe", 1'b1, flag_oe);
    wait_rst(1'b1, HOLD, n);
    in_range("power-up hold", HOLD, HOLD + 6, n + HOLD / 2);
  endtask : t_powerup

  task automatic t_brownout();
    supply_ok <= 1'b0;
    wait_rst(1'b0, 8, n);
    in_range("brownout", 1, 6, n);
    cyc(50);
    supply_ok <= 1'b1;
    cyc(100);
    supply_ok <= 1'b0;
    cyc(10);
    supply_ok <= 1'b1;
    wait_rst(1'b1, 2 * HOLD, n);
    in_range("hold restart", HOLD, HOLD + 6, n);
  endtask : t_brownout

  task automatic t_manual();
    ce_in_n <= 1'b0;
    cyc(6);
    chk("ce passes low", 1'b0, ce_out_n);
    chk("pullup off", 1'b0, ce_pullup);
    mr_n <= 1'b0;
    wait_rst(1'b0, 8, n);
    in_range("manual assert", 1, 6, n);
    cyc(20);
    chk("ce lingers", 1'b0, ce_out_n);
    ce_in_n <= 1'b1;
    cyc(6);
    chk("linger ends", 1'b1, ce_out_n);
    chk("pullup on", 1'b1, ce_pullup);
    ce_in_n <= 1'b0;
    cyc(6);
    chk("ce ignored", 1'b1, ce_out_n);
    cyc(HOLD + 100);
    chk("reset while low", 1'b0, reset_n);
    mr_n <= 1'b1;
    wait_rst(1'b1, 2 * HOLD, n);
    in_range("manual release", HOLD, HOLD + 6, n);
    ce_in_n <= 1'b1;
    cyc(6);
    chk("ce passes high", 1'b1, ce_out_n);
  endtask : t_manual

  task automatic t_regs();
    apb(1'b0, CTRL_ADDR, 32'h0);
    chkw("ctrl reset", CTRL_RESET_VAL, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 1'b1, err);
    chkw("unmapped data", 32'h0, rd);
    ce_in_n <= 1'b0;
    cyc(6);
    apb(1'b1, CTRL_ADDR, 32'h1);
    apb(1'b0, CTRL_ADDR, 32'h0);
    chkw("ctrl readback", 32'h1, rd);
    cyc(100);
    chk("soft reset", 1'b0, reset_n);
    chk("linger", 1'b0, ce_out_n);
    cyc(int'(CE_LINGER_CYC));
    chk("linger timeout", 1'b1, ce_out_n);
    apb(1'b1, CTRL_ADDR, 32'h0);
    wait_rst(1'b1, 2 * HOLD, n);
    in_range("soft release", HOLD - 2, HOLD + 6, n);
    ce_in_n <= 1'b1;
  endtask : t_regs

  task automatic t_watchdog();
    cyc(2 * WD);
    chk("open pin serviced", 1'b1, reset_n);
    kick_en <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      kick_lvl <= 1'b1;
      cyc(int'(KICK_PULSE_CYC));
      kick_lvl <= 1'b0;
      if (i < 4) cyc(WD - 200);
    end
    chk("kicks serviced", 1'b1, reset_n);
    wait_rst(1'b0, WD + 20, n);
    in_range("expiry", WD, WD + 10, n);
    wait_rst(1'b1, HOLD + 20, n);
    in_range("wd reset len", HOLD - 2, HOLD + 6, n);
    wait_rst(1'b0, WD + 20, n);
    in_range("count from release", WD - 4, WD + 6, n);
    kick_en <= 1'b0;
    wait_rst(1'b1, HOLD + 20, n);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("trip sticky", 1'b1, rd[ST_WD_TRIP_BIT]);
  endtask : t_watchdog

  task automatic t_flag();
    sense_ok <= 1'b0;
    cyc(6);
    chk("flag low", 1'b0, flag_n);
    sense_ok <= 1'b1;
    cyc(6);
    chk("flag high", 1'b1, flag_n);
    above_cell <= 1'b0;
    cyc(6);
    chk("flag below cell", 1'b0, flag_n);
    chk("no backup", 1'b0, backup);
    chk("ram supply", 1'b0, ram_cell);
    supply_ok <= 1'b0;
    cyc(6);
    chk("backup", 1'b1, backup);
    chk("ram cell", 1'b1, ram_cell);
    chk("backup reset", 1'b0, reset_n);
    chk("backup ce out", 1'b1, ce_out_n);
    chk("backup ce hiz", 1'b1, ce_in_hiz);
    chk("backup kick off", 1'b0, kick_oe);
    above_cell <= 1'b1;
    cyc(6);
    chk("backup left", 1'b0, backup);
    chk("ram higher", 1'b0, ram_cell);
    supply_ok <= 1'b1;
    wait_rst(1'b1, 2 * HOLD, n);
  endtask : t_flag

  task automatic t_seal();
    supply_ok <= 1'b0;
    cyc(10);
    ground_flag <= 1'b1;
    supply_ok <= 1'b1;
    cyc(HOLD / 2);
    mr_n <= 1'b0;
    cyc(10);
    mr_n <= 1'b1;
    wait_rst(1'b1, 2 * HOLD, n);
    in_range("mr ignored", HOLD / 2 - 12, HOLD / 2 + 6, n);
    supply_ok <= 1'b0;
    above_cell <= 1'b0;
    ground_flag <= 1'b0;
    cyc(20);
    chk("sealed backup", 1'b1, backup);
    chk("sealed no cell", 1'b0, ram_cell);
    apb(1'b0, STATUS_ADDR, 32'h0);
    chk("sealed status", 1'b1, rd[ST_SEALED_BIT]);
    supply_ok <= 1'b1;
    above_cell <= 1'b1;
    wait_rst(1'b1, 2 * HOLD, n);
    supply_ok <= 1'b0;
    above_cell <= 1'b0;
    cyc(6);
    chk("seal cleared", 1'b1, ram_cell);
  endtask : t_seal

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Run is about 20000 cycles; limit well above it
  initial begin
    #400000;
    err_count++;
    end_of_test();
  end

  initial begin
    {rstn, psel, penable, pwrite, supply_ok, sense_ok, kick_en, kick_lvl} = 8'h04;
    {above_cell, mr_n, ce_in_n, ground_ce, ground_flag} = 5'h1c;
    paddr = 12'h000;
    pwdata = 32'h0;
    cyc(5);
    rstn <= 1'b1;
    t_powerup();
    t_brownout();
    t_manual();
    t_regs();
    t_watchdog();
    t_flag();
    t_seal();
    end_of_test();
  end
endmodule : tb_supply_supervisor_watchdog
